// ==== hdl/sfb_core.sv ====
// Serial flash sequencer: transfer, compare, rewrite, status read, power-down
//
// Operation
// [R1] 53H: six skip, nine page, nine skip
// [R2] Binary mode transfer: seven, nine, eight
// [R3] Copy starts at select release; busy
// [R4] Host holds select low while clocking
// [R5] 60H compare, 264 layout six/nine/nine
// [R6] Binary compare: seven, nine, eight
// [R7] Compare busy, result in status bit 6
// [R8] 58H rewrite with page-size address layouts
// [R9] Rewrite: copy then program, stays busy
// [R10] Host rewrites sector pages every 10000 ops
// [R11] Status read accepted at any time; code refuses it while entering, in or waking from power-down
// [R12] Status MSB first, repeats fresh bytes
// [R13] Bit 7 one when ready, zero busy
// [R14] Self-timed operations clear ready bit
// [R15] Bit 1 shows sector protection enabled
// [R16] Bit 0 one for 256-byte pages
// [R17] Bits 5:2 fixed density code
// [R18] Standby after power-up
// [R19] B9H then select release: power-down
// [R20] In power-down only resume accepted
// [R21] ABH then release: standby after wake
// [R22] Host keeps select high during wake
// [R23] Host issues only status/id while busy
`timescale 1ns/100ps
module sfb_core #(
    parameter int REWRITE_CYCLES = sfb_pkg::REWRITE_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Serial link
    input  wire logic        cs_n_i,
    input  wire logic        sck_i,
    input  wire logic        si_i,
    output logic             so_o,
    output logic             so_oe_o,
    // Array side
    input  wire logic        protect_i,
    input  wire logic        binary_pages_i,
    input  wire logic        array_differs_i,
    output logic [8:0]       page_index_bits_o,
    output logic             copy_pulse_o,
    output logic             program_pulse_o,
    output logic             asleep_o
);
    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic cs_n_s;
    logic sck_s;
    logic si_s;
    // Select resets to its idle high level, so no false release edge
    sfb_sync #(.RESET_LEVEL(1'b1)) u_cs (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
                                         .pin_i(cs_n_i), .level_o(cs_n_s));
    sfb_sync u_ck (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(sck_i), .level_o(sck_s));
    sfb_sync u_si (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .pin_i(si_i), .level_o(si_s));

    logic cs_d;
    logic sck_d;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_d  <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            cs_d  <= cs_n_s;
            sck_d <= sck_s;
        end
    end
    wire cs_low  = ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_d;
    wire sck_up  = cs_low & sck_s & ~sck_d;
    wire sck_dn  = cs_low & ~sck_s & sck_d;

    ////////////////////////////////////////////////////////////////////
    // Command shifter
    logic [31:0] shreg;
    logic [5:0]  nbits;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shreg <= '0;
            nbits <= '0;
        end else if (cs_n_s) begin
            nbits <= '0;
        end else if (sck_up) begin
            shreg <= {shreg[30:0], si_s};                           // [R4]
            if (nbits != 6'd63) begin
                nbits <= nbits + 6'd1;
            end
        end
    end
    wire [7:0] opcode  = (nbits >= 6'd32) ? shreg[31:24] : shreg[7:0];
    wire       full    = (nbits == 6'd32);
    wire       op_only = (nbits == 6'd8);
    wire [23:0] addr   = shreg[23:0];

    function automatic logic [8:0] page_of(input logic [23:0] a, input logic bin);
        page_of = bin ? a[sfb_pkg::LO256 +: sfb_pkg::PAGE_W]      // [R2] [R6]
                      : a[sfb_pkg::LO264 +: sfb_pkg::PAGE_W];     // [R1] [R5]
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Sequencer
    sfb_pkg::sfb_state_type state;
    logic                   load;
    logic [sfb_pkg::CNT_W-1:0] load_cnt;
    logic                   done;
    logic                   match_flag;
    logic                   rew_second;
    sfb_timer u_tmr (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .load_i(load),
                     .count_i(load_cnt), .done_o(done));

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state             <= sfb_pkg::SFB_IDLE;                 // [R18]
            load              <= 1'b0;
            load_cnt          <= '0;
            match_flag        <= 1'b0;
            rew_second        <= 1'b0;
            page_index_bits_o <= '0;
            copy_pulse_o      <= 1'b0;
            program_pulse_o   <= 1'b0;
            asleep_o          <= 1'b0;
        end else begin
            load            <= 1'b0;
            copy_pulse_o    <= 1'b0;
            program_pulse_o <= 1'b0;
            unique case (state)
                sfb_pkg::SFB_IDLE: begin
                    if (cs_rise && full) begin
                        page_index_bits_o <= page_of(addr, binary_pages_i);
                        if (opcode == sfb_pkg::OP_COPY) begin      // [R3]
                            state        <= sfb_pkg::SFB_COPY;
                            copy_pulse_o <= 1'b1;
                            load         <= 1'b1;
                            load_cnt     <= sfb_pkg::CNT_W'(sfb_pkg::COPY_CYC);
                        end else if (opcode == sfb_pkg::OP_MATCH) begin
                            state    <= sfb_pkg::SFB_MATCH;       // [R7]
                            load     <= 1'b1;
                            load_cnt <= sfb_pkg::CNT_W'(sfb_pkg::MATCH_CYC);
                        end else if (opcode == sfb_pkg::OP_REWRITE) begin // [R8]
                            state        <= sfb_pkg::SFB_REWRITE; // [R9]
                            copy_pulse_o <= 1'b1;
                            rew_second   <= 1'b0;
                            load         <= 1'b1;
                            load_cnt     <= sfb_pkg::CNT_W'(REWRITE_CYCLES / 2);
                        end
                    end else if (cs_rise && op_only && opcode == sfb_pkg::OP_SLEEP) begin
                        state    <= sfb_pkg::SFB_ENTER;               // [R19]
                        load     <= 1'b1;
                        load_cnt <= sfb_pkg::CNT_W'(sfb_pkg::SLEEP_CYC);
                    end
                end
                sfb_pkg::SFB_COPY: begin
                    if (done) begin
                        state <= sfb_pkg::SFB_IDLE;
                    end
                end
                sfb_pkg::SFB_MATCH: begin
                    if (done) begin
                        match_flag <= array_differs_i;                // [R7]
                        state      <= sfb_pkg::SFB_IDLE;
                    end
                end
                sfb_pkg::SFB_REWRITE: begin
                    if (done && !rew_second) begin
                        rew_second      <= 1'b1;                      // [R9]
                        program_pulse_o <= 1'b1;
                        load            <= 1'b1;
                        load_cnt        <= sfb_pkg::CNT_W'(REWRITE_CYCLES / 2);
                    end else if (done) begin
                        state <= sfb_pkg::SFB_IDLE;
                    end
                end
                sfb_pkg::SFB_ENTER: begin
                    if (done) begin
                        state    <= sfb_pkg::SFB_SLEEP;
                        asleep_o <= 1'b1;
                    end
                end
                sfb_pkg::SFB_SLEEP: begin
                    if (cs_rise && op_only && opcode == sfb_pkg::OP_WAKE) begin
                        state    <= sfb_pkg::SFB_WAKE;                // [R21]
                        load     <= 1'b1;
                        load_cnt <= sfb_pkg::CNT_W'(sfb_pkg::WAKE_CYC);
                    end                                               // [R20]
                end
                sfb_pkg::SFB_WAKE: begin
                    if (done) begin
                        state    <= sfb_pkg::SFB_IDLE;
                        asleep_o <= 1'b0;
                    end
                end
                default: state <= sfb_pkg::SFB_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Status byte
    wire busy = (state == sfb_pkg::SFB_COPY) || (state == sfb_pkg::SFB_MATCH)
             || (state == sfb_pkg::SFB_REWRITE);                     // [R14]
    logic [7:0] status;
    always_comb begin
        status                        = sfb_pkg::STATUS_RESET;
        status[sfb_pkg::ST_READY_BIT] = ~busy;                       // [R13]
        status[sfb_pkg::ST_MATCH_BIT] = match_flag;                  // [R7]
        status[5:2]                   = sfb_pkg::DENSITY_CODE;      // [R17]
        status[sfb_pkg::ST_PROT_BIT]  = protect_i;                   // [R15]
        status[sfb_pkg::ST_SIZE_BIT]  = binary_pages_i;              // [R16]
    end

    ////////////////////////////////////////////////////////////////////
    // Status read-out
    logic       reading;
    logic [7:0] out_sh;
    logic [2:0] out_cnt;
    wire awake = (state != sfb_pkg::SFB_SLEEP) && (state != sfb_pkg::SFB_ENTER)
              && (state != sfb_pkg::SFB_WAKE);
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reading <= 1'b0;
            out_sh  <= '0;
            out_cnt <= '0;
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else if (cs_n_s) begin
            reading <= 1'b0;
            so_oe_o <= 1'b0;
        end else if (sck_up && !reading && nbits == 6'd7 && awake
                     && {shreg[6:0], si_s} == sfb_pkg::OP_STATUS) begin
            reading <= 1'b1;                                         // [R11]
            out_sh  <= status;
            out_cnt <= '0;
        end else if (reading && sck_dn) begin
            so_oe_o <= 1'b1;
            so_o    <= out_sh[7];                                    // [R12]
            if (out_cnt == 3'd7) begin
                out_sh <= status;
            end else begin
                out_sh <= {out_sh[6:0], 1'b0};
            end
            out_cnt <= out_cnt + 3'd1;
        end
    end
endmodule

// ==== hdl/sfb_pkg.sv ====
// Package with opcodes, status layout and timing constants for the flash sequencer
package sfb_pkg;
    localparam int          CLK_HZ            = 20_000_000;
    localparam logic [7:0]  OP_COPY           = 8'h53;
    localparam logic [7:0]  OP_MATCH          = 8'h60;
    localparam logic [7:0]  OP_REWRITE        = 8'h58;
    localparam logic [7:0]  OP_STATUS         = 8'hD7;
    localparam logic [7:0]  OP_SLEEP          = 8'hB9;
    localparam logic [7:0]  OP_WAKE           = 8'hAB;
    localparam int          ST_READY_BIT      = 7;
    localparam int          ST_MATCH_BIT      = 6;
    localparam int          ST_PROT_BIT       = 1;
    localparam int          ST_SIZE_BIT       = 0;
    // Density code: arbitrary neutral value
    localparam logic [3:0]  DENSITY_CODE      = 4'h5;
    localparam logic [7:0]  STATUS_RESET      = 8'h80;
    localparam int          ADDR_BITS         = 24;
    localparam int          PAGE_W            = 9;
    localparam int          LO264             = 9;
    localparam int          LO256             = 8;
    // Times in microseconds
    localparam int          COPY_TIME_US        = 200;
    localparam int          MATCH_TIME_US       = 200;
    localparam int          REWRITE_TIME_US     = 20_000;
    localparam int          SLEEP_ENTRY_TIME_US = 3;
    localparam int          WAKE_TIME_US        = 35;
    localparam int          COPY_CYC    = COPY_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          MATCH_CYC   = MATCH_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          REWRITE_CYC = REWRITE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          SLEEP_CYC   = SLEEP_ENTRY_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          WAKE_CYC    = WAKE_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          CNT_W       = 20;
    typedef enum logic [2:0] {
        SFB_IDLE, SFB_COPY, SFB_MATCH, SFB_REWRITE, SFB_ENTER, SFB_SLEEP, SFB_WAKE
    } sfb_state_type;
endpackage

// ==== hdl/sfb_sync.sv ====
// Two-flop synchroniser for one pin level
`timescale 1ns/100ps
module sfb_sync #(
    parameter logic RESET_LEVEL = 1'b0
) (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // Level
    input  wire logic pin_i,
    output logic      level_o
);
    logic meta;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta    <= RESET_LEVEL;
            level_o <= RESET_LEVEL;
        end else begin
            meta    <= pin_i;
            level_o <= meta;
        end
    end
endmodule

// ==== hdl/sfb_timer.sv ====
// Down counter that pulses done after a loaded number of cycles
`timescale 1ns/100ps
module sfb_timer (
    // Clock and reset
    input  wire logic                     sys_clk_i,
    input  wire logic                     rst_i,
    // Control
    input  wire logic                     load_i,
    input  wire logic [sfb_pkg::CNT_W-1:0] count_i,
    output logic                          done_o
);
    logic [sfb_pkg::CNT_W-1:0] remain;
    logic                      running;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            remain  <= '0;
            running <= 1'b0;
            done_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (load_i) begin
                remain  <= count_i;
                running <= 1'b1;
            end else if (running) begin
                if (remain <= sfb_pkg::CNT_W'(1)) begin
                    running <= 1'b0;
                    done_o  <= 1'b1;
                end else begin
                    remain <= remain - 1'b1;
                end
            end
        end
    end
endmodule

// ==== sim/sfb_checker.sv ====
// Port assertions for the flash sequencer
`timescale 1ns/100ps
module sfb_checker #(
    parameter int REWRITE_CYCLES = 200
) (
    // Clock and reset
    input wire logic       sys_clk_i,
    input wire logic       rst_i,
    // Serial link
    input wire logic       cs_n_i,
    input wire logic       sck_i,
    input wire logic       si_i,
    input wire logic       so_o,
    input wire logic       so_oe_o,
    // Array side
    input wire logic       protect_i,
    input wire logic       binary_pages_i,
    input wire logic       array_differs_i,
    input wire logic [8:0] page_index_bits_o,
    input wire logic       copy_pulse_o,
    input wire logic       program_pulse_o,
    input wire logic       asleep_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since the last copy pulse
    int since_copy;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            since_copy <= 0;
        end else if (copy_pulse_o) begin
            since_copy <= 0;
        end else if (since_copy < REWRITE_CYCLES) begin
            since_copy <= since_copy + 1;
        end
    end
    oe_idle_a: assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("so driven while deselected");
    oe_start_a: assert property ($rose(so_oe_o) |-> !cs_n_i && !asleep_o)
        else $error("so drive began outside a frame");
    so_hold_a: assert property (so_oe_o && sck_i && $past(sck_i, 2) |-> $stable(so_o))
        else $error("so moved while clock high");
    copy_once_a: assert property (copy_pulse_o |=> !copy_pulse_o)
        else $error("copy pulse too long");
    copy_sel_a: assert property (copy_pulse_o |-> cs_n_i && $past(cs_n_i, 2))
        else $error("copy began with select low");
    prog_once_a: assert property (program_pulse_o |=> !program_pulse_o)
        else $error("program pulse too long");
    prog_sel_a: assert property (program_pulse_o
        |-> !copy_pulse_o && since_copy == REWRITE_CYCLES / 2 + 1)
        else $error("program pulse out of place");
    sleep_quiet_a: assert property (asleep_o |-> !copy_pulse_o && !program_pulse_o)
        else $error("operation started while asleep");
    sleep_oe_a: assert property (asleep_o |-> !so_oe_o)
        else $error("status answered while asleep");
    sleep_in_a: assert property ($rose(asleep_o) |-> cs_n_i && $past(cs_n_i, 8))
        else $error("sleep entered early");
    wake_out_a: assert property ($fell(asleep_o) |-> cs_n_i && $past(cs_n_i, 8))
        else $error("wake left early");
endmodule
bind sfb_core sfb_checker #(.REWRITE_CYCLES(REWRITE_CYCLES)) chk (.sys_clk_i, .rst_i,
    .cs_n_i, .sck_i, .si_i, .so_o, .so_oe_o, .protect_i, .binary_pages_i, .array_differs_i,
    .page_index_bits_o, .copy_pulse_o, .program_pulse_o, .asleep_o);

// ==== sim/sfb_host.sv ====
// SPI host model, mode 0, MSB first
`timescale 1ns/100ps
module sfb_host (
    // Clock
    input  wire logic sys_clk_i,
    // Link
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    // Select held low for the whole frame
    task automatic frame(input logic [31:0] d, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge sys_clk_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        for (int i = 0; i < n; i++) begin
            sck_o <= 1'b0;
            si_o  <= d[31-i];
            repeat (4) @(posedge sys_clk_i);
            sck_o <= 1'b1;
            repeat (4) @(posedge sys_clk_i);
            rx = {rx[14:0], so_i};
        end
        sck_o <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        cs_n_o <= 1'b1;
        si_o   <= ~si_o;
        repeat (8) @(posedge sys_clk_i);
    endtask
endmodule

// ==== sim/sfb_core_tb.sv ====
// Self-checking bench for the flash sequencer
`timescale 1ns/100ps
module sfb_core_tb;
    logic        sys_clk, rst, cs_n, sck, si, so, so_oe, copy_p, prog_p, asleep;
    logic        protect, binary, differs, cmpr;
    logic [8:0]  page;
    logic [15:0] rx;
    int          errors, comparisons, copies, progs;
    sfb_core #(.REWRITE_CYCLES(200)) dut (.sys_clk_i(sys_clk), .rst_i(rst), .cs_n_i(cs_n),
        .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe), .protect_i(protect),
        .binary_pages_i(binary), .array_differs_i(differs), .page_index_bits_o(page),
        .copy_pulse_o(copy_p), .program_pulse_o(prog_p), .asleep_o(asleep));
    sfb_host host (.sys_clk_i(sys_clk), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so));
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (copy_p === 1'b1) copies++;
        if (prog_p === 1'b1) progs++;
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    function automatic logic [15:0] st(input logic r);
        return {8'h00, r, cmpr, sfb_pkg::DENSITY_CODE, protect, binary};
    endfunction
    task automatic stat(output logic [15:0] s);
        host.frame({sfb_pkg::OP_STATUS, 24'h0}, 24, rx);
        s = {8'h00, rx[15:8]};
    endtask
    task automatic wait_ready();
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < 60 && s[7] !== 1'b1; i++) stat(s);
        check(s, st(1'b1), "ready status");
    endtask
    task automatic op_run(input logic [7:0] op, input logic b, input logic d,
                          input logic [8:0] pg, input int nc, input int np);
        logic [15:0] s;
        int c, p;
        @(posedge sys_clk);
        binary  <= b;
        differs <= d;
        c = copies;
        p = progs;
        host.frame({op, b ? {7'h00, pg, 8'h00} : {6'h00, pg, 9'h000}}, 32, rx);
        stat(s);
        check(s, st(1'b0), "busy status");
        check(16'(page), 16'(pg), "page index");
        if (op == sfb_pkg::OP_MATCH) cmpr = d;
        wait_ready();
        check(16'(copies - c), 16'(nc), "copy count");
        check(16'(progs - p), 16'(np), "program count");
    endtask
    task automatic t_status();
        logic [15:0] s;
        stat(s);
        check(s, 16'h0096, "reset status");
        check({8'h00, rx[7:0]}, s, "repeated byte");
        check(16'(so_oe), 16'h0, "so released");
        $display("status test done");
    endtask
    task automatic t_copy();
        op_run(sfb_pkg::OP_COPY, 1'b0, 1'b0, 9'h1A5, 1, 0);
        op_run(sfb_pkg::OP_COPY, 1'b1, 1'b0, 9'h05A, 1, 0);
        $display("copy test done");
    endtask
    task automatic t_match();
        op_run(sfb_pkg::OP_MATCH, 1'b0, 1'b1, 9'h1FF, 0, 0);
        op_run(sfb_pkg::OP_MATCH, 1'b1, 1'b0, 9'h100, 0, 0);
        $display("compare test done");
    endtask
    task automatic t_rewrite();
        op_run(sfb_pkg::OP_REWRITE, 1'b0, 1'b0, 9'h001, 1, 1);
        op_run(sfb_pkg::OP_REWRITE, 1'b1, 1'b0, 9'h0F0, 1, 1);
        $display("rewrite test done");
    endtask
    task automatic t_sleep();
        logic [15:0] s;
        int c;
        host.frame({sfb_pkg::OP_SLEEP, 24'h0}, 8, rx);
        repeat (sfb_pkg::SLEEP_CYC) @(posedge sys_clk);
        check(16'(asleep), 16'h1, "asleep");
        c = copies;
        host.frame({sfb_pkg::OP_COPY, 24'h0}, 32, rx);
        stat(s);
        check(16'(copies - c), 16'h0, "copy while asleep");
        check(16'(asleep), 16'h1, "still asleep");
        host.frame({sfb_pkg::OP_WAKE, 24'h0}, 8, rx);
        repeat (sfb_pkg::WAKE_CYC) @(posedge sys_clk);
        check(16'(asleep), 16'h0, "awake");
        stat(s);
        check(s, st(1'b1), "status after wake");
        $display("sleep test done");
    endtask
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge sys_clk);
        errors++;
        test_done();
    end
    initial begin
        {errors, comparisons, copies, progs} = '0;
        {rst, protect, binary, differs, cmpr} = 5'b11000;
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_status();
        t_copy();
        t_match();
        t_rewrite();
        t_sleep();
        test_done();
    end
endmodule
